// ==== exc_consts.svh ====
`ifndef EXC_CONSTS_SVH
`define EXC_CONSTS_SVH

// ============================================================
// register offsets (byte addresses, 64-bit words)
`define REG_MSW_OFF 5'h00
`define REG_SRPC_OFF 5'h08
`define REG_SRST_OFF 5'h10
`define REG_RSTCAUSE_OFF 5'h18

// ============================================================
// machine state word fields, vector index = 63 - architected bit
`define MSW_WIDE 63
`define MSW_EXC_WIDE 61
`define MSW_LOWPWR 18
`define MSW_EXC_LE 16
`define MSW_AIE 15
`define MSW_USER 14
`define MSW_FPAVAIL 13
`define MSW_MCE 12
`define MSW_FEXC_LO 11
`define MSW_STEP 10
`define MSW_BRTRACE 9
`define MSW_FEXC_HI 8
`define MSW_VEC_HI 6
`define MSW_ITRANS 5
`define MSW_DTRANS 4
`define MSW_RECOV 1
`define MSW_BYTESWAP 0

// implemented bits; the rest reads as zero
`define MSW_IMPL_MASK 64'ha000_0000_0005_ff73
// architected bits 0, 48-55, 57-59, 63 copied on entry
`define SRST_COPY_MASK 64'h8000_0000_0000_ff71
// architected bits 33-36 and 42-47 carry exception information
`define SRST_INFO_HI 30
`define SRST_INFO_HI_LO 27
`define SRST_INFO_LO_HI 21
`define SRST_INFO_LO 16

// ============================================================
// vectors
`define VEC_SYS_RESET 20'h00100
`define VEC_HIGH_BASE 64'h0000_0000_fff0_0000

// reset cause register fields
`define RC_POWER_ON 0
`define RC_SOFT 1

`endif

// ==== exc_pkg.sv ====
package exc_pkg;
    typedef enum logic [0:0] {
        ST_RUN,
        ST_DRAIN
    } entry_state_t;
    typedef logic [63:0] word_t;
endpackage : exc_pkg

// ==== exc_vector.sv ====
`timescale 1ns/10ps
`include "exc_consts.svh"

module exc_vector (
    // selection
    input wire logic vecHigh,
    input wire logic [19:0] offset,
    // result
    output logic [63:0] vecAddr
);
    // ============================================================
    // base is zero or 0xfff00000 above the offset field
    wire [63:0] baseAddr = vecHigh ? `VEC_HIGH_BASE : 64'h0;
    assign vecAddr = baseAddr | {44'h0, offset};
endmodule : exc_vector

// ==== exception_entry_state.sv ====
`timescale 1ns/10ps
`include "exc_consts.svh"

// Behaviour
// - any entry clears power, interrupt enable, mode, float, trace, translate, recover bits
// - machine check enable cleared only by machine check entry
// - byte order bit takes exception little endian value on entry
// - wide mode set on entry, or copied from exception wide select
// - reserved state word bits are not stored and read zero
// - selected state word bits saved before the word is overwritten
// - system reset request is non-maskable and asynchronous
// - saved pc on system reset is the next instruction address
// - system reset saves copy bits and clears information bits
// - saved recover bit copies flag when recoverable, else cleared
// - system reset fetch resumes at offset 0x00100 from vector base
// - recoverable system reset waits for prior instructions to complete
// - lost external, decrementer, store error or float exception means unrecoverable
// - unrecoverable system reset enters without waiting for prior instructions
// - software can tell power-on reset from a soft reset
// - vector base zero or 0xfff00000 above the offset
// - new state word governs the first handler fetch
// - external and decrementer requests held off while enable is clear
module exception_entry_state
    import exc_pkg::*;
#(
    parameter bit WIDE_IMPL = 1'b1,
    parameter bit EXC_WIDE_IMPL = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // system reset request pin
    input wire logic sysResetReq,
    // instruction sequencer
    input wire logic [63:0] nextPc,
    input wire logic priorDone,
    input wire logic excReq,
    input wire logic excIsMachineCheck,
    input wire logic [19:0] excOffset,
    input wire logic [9:0] excInfo,
    input wire logic asyncReq,
    input wire logic [19:0] asyncOffset,
    // losses that make a system reset unrecoverable
    input wire logic lostAsyncInt,
    input wire logic lostStoreError,
    input wire logic lostFloatProgram,
    // register port
    input wire logic [4:0] regAddr,
    input wire logic [63:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [63:0] regRdData,
    // towards fetch and execution
    output logic fetchRedirect,
    output logic [63:0] fetchAddr,
    output logic excAck,
    output logic asyncAck,
    output logic [63:0] machineStateWord
);

    // ============================================================
    // state
    word_t msw_ff;
    word_t srPc_ff;
    word_t srState_ff;
    logic [1:0] resetCause_ff;
    logic syncA_ff;
    logic syncB_ff;
    logic syncC_ff;
    logic resetPend_ff;
    logic drainRecov_ff;
    entry_state_t state_ff;
    entry_state_t nxt_state;
    word_t rdData_ff;
    logic redirect_ff;
    word_t fetchAddr_ff;
    logic excAck_ff;
    logic asyncAck_ff;

    // ============================================================
    // request selection
    wire resetEdge = syncB_ff & ~syncC_ff;
    wire resetSeen = resetEdge | resetPend_ff;
    wire lossAny = lostAsyncInt | lostStoreError | lostFloatProgram;
    wire recoverNow = ~lossAny;
    // an unrecoverable reset does not wait for older instructions
    wire resetGo = (state_ff == ST_DRAIN) ? (priorDone | lossAny)
                                          : (resetSeen & lossAny);
    wire resetDrain = (state_ff == ST_RUN) & resetSeen & ~lossAny;
    // reset owns the entry slot; other requests retry later
    wire blockOthers = resetSeen | (state_ff == ST_DRAIN);
    wire syncGo = excReq & ~blockOthers;
    wire asyncGo = asyncReq & msw_ff[`MSW_AIE] & ~blockOthers & ~excReq;
    wire enterAny = resetGo | syncGo | asyncGo;
    wire resetRecov = (state_ff == ST_DRAIN) ? (drainRecov_ff & recoverNow) : 1'b0;

    // ============================================================
    // new state word
    function automatic word_t entry_msw(input word_t cur, input logic isMchk);
        word_t m;
        m = cur;
        m[`MSW_LOWPWR] = 1'b0;
        m[`MSW_AIE] = 1'b0;
        m[`MSW_USER] = 1'b0;
        m[`MSW_FPAVAIL] = 1'b0;
        m[`MSW_FEXC_LO] = 1'b0;
        m[`MSW_STEP] = 1'b0;
        m[`MSW_BRTRACE] = 1'b0;
        m[`MSW_FEXC_HI] = 1'b0;
        m[`MSW_ITRANS] = 1'b0;
        m[`MSW_DTRANS] = 1'b0;
        m[`MSW_RECOV] = 1'b0;
        if (isMchk) begin
            m[`MSW_MCE] = 1'b0;
        end
        m[`MSW_BYTESWAP] = cur[`MSW_EXC_LE];
        if (WIDE_IMPL) begin
            m[`MSW_WIDE] = EXC_WIDE_IMPL ? cur[`MSW_EXC_WIDE] : 1'b1;
        end
        return m & `MSW_IMPL_MASK;
    endfunction : entry_msw

    // saved state: copy bits, information bits, recover bit
    function automatic word_t entry_srst(input word_t cur, input logic [9:0] info,
                                         input logic recov);
        word_t s;
        s = cur & `SRST_COPY_MASK;
        s[`SRST_INFO_HI:`SRST_INFO_HI_LO] = info[9:6];
        s[`SRST_INFO_LO_HI:`SRST_INFO_LO] = info[5:0];
        s[`MSW_RECOV] = recov & cur[`MSW_RECOV];
        return s;
    endfunction : entry_srst

    wire isMchk = syncGo & excIsMachineCheck;
    wire word_t nxt_msw_entry = entry_msw(msw_ff, isMchk);
    // system reset leaves information bits clear
    wire [9:0] infoSel = resetGo ? 10'h000 : (syncGo ? excInfo : 10'h000);
    wire recovSel = resetGo ? resetRecov : 1'b1;
    wire word_t nxt_srst_entry = entry_srst(msw_ff, infoSel, recovSel);
    wire [19:0] offSel = resetGo ? `VEC_SYS_RESET : (syncGo ? excOffset : asyncOffset);
    logic [63:0] vecAddr;

    exc_vector u_vec (
        .vecHigh(msw_ff[`MSW_VEC_HI]),
        .offset(offSel),
        .vecAddr(vecAddr)
    );

    // ============================================================
    // register port decode
    wire wrMsw = regWr & (regAddr == `REG_MSW_OFF);
    wire wrSrPc = regWr & (regAddr == `REG_SRPC_OFF);
    wire wrSrst = regWr & (regAddr == `REG_SRST_OFF);
    wire wrCause = regWr & (regAddr == `REG_RSTCAUSE_OFF);
    wire word_t rdMux = (regAddr == `REG_MSW_OFF) ? msw_ff :
                        (regAddr == `REG_SRPC_OFF) ? srPc_ff :
                        (regAddr == `REG_SRST_OFF) ? srState_ff :
                        (regAddr == `REG_RSTCAUSE_OFF) ? {62'h0, resetCause_ff} :
                        64'h0;
    // entry beats a same-cycle software write so the three words stay consistent
    wire word_t nxt_msw = enterAny ? nxt_msw_entry :
                          (wrMsw ? (regWrData & `MSW_IMPL_MASK) : msw_ff);
    wire word_t nxt_srPc = enterAny ? nextPc : (wrSrPc ? regWrData : srPc_ff);
    wire word_t nxt_srState = enterAny ? nxt_srst_entry :
                              (wrSrst ? regWrData : srState_ff);
    // write one to clear; a new soft reset wins over the clear
    wire [1:0] nxt_cause = (resetCause_ff & ~(wrCause ? regWrData[1:0] : 2'b00)) |
                           {resetGo, 1'b0};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (resetDrain) begin
                    nxt_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (resetGo) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // ============================================================
    // synchroniser for the request pin
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            syncA_ff <= 1'b0;
            syncB_ff <= 1'b0;
            syncC_ff <= 1'b0;
        end else begin
            syncA_ff <= sysResetReq;
            syncB_ff <= syncA_ff;
            syncC_ff <= syncB_ff;
        end
    end

    // ============================================================
    // sequencing
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= ST_RUN;
            resetPend_ff <= 1'b0;
            drainRecov_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            resetPend_ff <= resetSeen & ~resetGo & ~resetDrain;
            drainRecov_ff <= resetDrain ? recoverNow : (drainRecov_ff & recoverNow);
        end
    end

    // ============================================================
    // architected registers, one update per entry
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            msw_ff <= 64'h0;
            srPc_ff <= 64'h0;
            srState_ff <= 64'h0;
            resetCause_ff <= 2'b01;
        end else begin
            msw_ff <= nxt_msw;
            srPc_ff <= nxt_srPc;
            srState_ff <= nxt_srState;
            resetCause_ff <= nxt_cause;
        end
    end

    // ============================================================
    // outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdData_ff <= 64'h0;
            redirect_ff <= 1'b0;
            fetchAddr_ff <= 64'h0;
            excAck_ff <= 1'b0;
            asyncAck_ff <= 1'b0;
        end else begin
            rdData_ff <= regRd ? rdMux : 64'h0;
            // redirect lands with the new word, so the first fetch sees it
            redirect_ff <= enterAny;
            fetchAddr_ff <= enterAny ? vecAddr : fetchAddr_ff;
            excAck_ff <= syncGo;
            asyncAck_ff <= asyncGo;
        end
    end

    assign regRdData = rdData_ff;
    assign fetchRedirect = redirect_ff;
    assign fetchAddr = fetchAddr_ff;
    assign excAck = excAck_ff;
    assign asyncAck = asyncAck_ff;
    assign machineStateWord = msw_ff;

endmodule : exception_entry_state

// ==== exception_entry_state_properties.sv ====
`timescale 1ns/10ps
`include "exc_consts.svh"
// ============================================================
// entry checks
module exception_entry_state_properties
    import exc_pkg::*;
#(
    parameter bit WIDE_IMPL = 1'b1,
    parameter bit EXC_WIDE_IMPL = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // watched ports
    input wire logic excIsMachineCheck,
    input wire logic fetchRedirect,
    input wire logic [63:0] fetchAddr,
    input wire logic excAck,
    input wire logic asyncAck,
    input wire logic [63:0] machineStateWord
);
    // bits that every entry must clear
    localparam word_t CLR = 64'h0000_0000_0004_ef32;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ack_with_redirect: assert property (excAck |-> fetchRedirect)
        else $error("ack without redirect");
    a_entry_clears_bits: assert property (fetchRedirect |-> (machineStateWord & CLR) == 64'h0)
        else $error("entry left a bit set");
    a_keep_le_vec: assert property (fetchRedirect |-> machineStateWord[`MSW_EXC_LE] == $past(machineStateWord[`MSW_EXC_LE]) && $stable(machineStateWord[`MSW_VEC_HI]))
        else $error("entry altered kept bits");
    a_byte_order_copy: assert property (fetchRedirect |-> machineStateWord[`MSW_BYTESWAP] == $past(machineStateWord[`MSW_EXC_LE]))
        else $error("byte order not copied");
    a_wide_mode_set: assert property (fetchRedirect |-> machineStateWord[`MSW_WIDE] == (EXC_WIDE_IMPL ? $past(machineStateWord[`MSW_EXC_WIDE]) : WIDE_IMPL))
        else $error("wide mode wrong");
    a_mce_cleared: assert property (excAck && $past(excIsMachineCheck) |-> !machineStateWord[`MSW_MCE])
        else $error("machine check enable kept");
    a_mce_kept: assert property (fetchRedirect && !(excAck && $past(excIsMachineCheck)) |-> $stable(machineStateWord[`MSW_MCE]))
        else $error("machine check enable changed");
    a_reset_vector: assert property (fetchRedirect && !excAck && !asyncAck |-> fetchAddr == ((machineStateWord[`MSW_VEC_HI] ? `VEC_HIGH_BASE : 64'h0) | 64'h100))
        else $error("reset vector wrong");
    a_async_masked: assert property (asyncAck |-> $past(machineStateWord[`MSW_AIE]))
        else $error("async taken while masked");
endmodule : exception_entry_state_properties

bind exception_entry_state exception_entry_state_properties #(
    .WIDE_IMPL(WIDE_IMPL), .EXC_WIDE_IMPL(EXC_WIDE_IMPL)
) chk (.core_clk(core_clk), .rst_n(rst_n), .excIsMachineCheck(excIsMachineCheck),
    .fetchRedirect(fetchRedirect), .fetchAddr(fetchAddr), .excAck(excAck),
    .asyncAck(asyncAck), .machineStateWord(machineStateWord));

// ==== reset_source.sv ====
`timescale 1ns/10ps
// ============================================================
// system logic raising the reset request pin
module reset_source #(
    parameter int HOLD = 6
) (
    // clock and trigger
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [3:0] skew,
    // request pin
    output logic sysResetReq
);
    // pin moves off the clock edge, never on it, so no race
    initial sysResetReq = 1'b0;
    always @(posedge fire) begin
        #(skew[2:0] + 1) sysResetReq = 1'b1;
        repeat (HOLD) @(posedge core_clk);
        #(skew[2:0] + 1) sysResetReq = 1'b0;
    end
endmodule : reset_source

// ==== test_exception_entry_state.sv ====
`timescale 1ns/10ps
`include "exc_consts.svh"
// ============================================================
// bench
module test_exception_entry_state import exc_pkg::*;;
    logic core_clk, rst_n, sysResetReq, priorDone, excReq, excIsMachineCheck, asyncReq, fire;
    logic lostAsyncInt, lostStoreError, lostFloatProgram, regWr, regRd, fetchRedirect, excAck, asyncAck;
    word_t nextPc, regWrData, regRdData, fetchAddr, machineStateWord;
    logic [19:0] excOffset, asyncOffset;
    logic [9:0] excInfo;
    logic [4:0] regAddr;
    logic [3:0] skew;
    int nMismatch = 0, checksDone = 0, nRedir = 0, k;
    exception_entry_state DUT (.core_clk(core_clk), .rst_n(rst_n), .sysResetReq(sysResetReq),
        .nextPc(nextPc), .priorDone(priorDone), .excReq(excReq), .excIsMachineCheck(excIsMachineCheck),
        .excOffset(excOffset), .excInfo(excInfo), .asyncReq(asyncReq), .asyncOffset(asyncOffset),
        .lostAsyncInt(lostAsyncInt), .lostStoreError(lostStoreError),
        .lostFloatProgram(lostFloatProgram), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .fetchRedirect(fetchRedirect),
        .fetchAddr(fetchAddr), .excAck(excAck), .asyncAck(asyncAck),
        .machineStateWord(machineStateWord));
    reset_source src (.core_clk(core_clk), .fire(fire), .skew(skew), .sysResetReq(sysResetReq));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // counted mid-cycle, away from the edge that launches the pulse
    always @(negedge core_clk) if (fetchRedirect === 1'b1) nRedir++;
    // ============================================================
    // expectations
    function automatic word_t expWord(word_t o, logic mc);
        word_t w;
        w = o & ~64'h0000_0000_0004_ef32;
        if (mc) w[`MSW_MCE] = 1'b0;
        w[`MSW_BYTESWAP] = o[`MSW_EXC_LE];
        w[`MSW_WIDE] = 1'b1;
        return w;
    endfunction : expWord
    function automatic word_t expSave(word_t o, logic [9:0] inf, logic rec);
        word_t s;
        s = o & `SRST_COPY_MASK;
        s[30:27] = inf[9:6];
        s[21:16] = inf[5:0];
        s[`MSW_RECOV] = rec;
        return s;
    endfunction : expSave
    // ============================================================
    // tasks
    task automatic check(input word_t g, input word_t e);
        checksDone++;
        if (g !== e) begin
            nMismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : check
    task automatic regWrite(input logic [4:0] a, input word_t d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [4:0] a, input word_t e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 check(regRdData, e);
        @(posedge core_clk);
    endtask : regRead
    task automatic waitRedirect(input int n);
        for (int i = 0; i < n && fetchRedirect !== 1'b1; i++) @(posedge core_clk) #1;
        check(64'(fetchRedirect), 64'h1);
    endtask : waitRedirect
    task automatic doEntry(input logic mc);
        word_t o, pc;
        logic [19:0] off;
        logic [9:0] inf;
        o = {$urandom, $urandom} & `MSW_IMPL_MASK;
        pc = {$urandom, $urandom};
        off = 20'($urandom);
        inf = 10'($urandom);
        regWrite(`REG_MSW_OFF, o);
        {nextPc, excOffset, excInfo, excIsMachineCheck} <= {pc, off, inf, mc};
        excReq <= 1'b1;
        @(posedge core_clk);
        excReq <= 1'b0;
        #1 check(64'(excAck), 64'h1);
        check(fetchAddr, (o[`MSW_VEC_HI] ? `VEC_HIGH_BASE : 64'h0) | 64'(off));
        @(posedge core_clk);
        regRead(`REG_MSW_OFF, expWord(o, mc));
        regRead(`REG_SRPC_OFF, pc);
        regRead(`REG_SRST_OFF, expSave(o, inf, o[`MSW_RECOV]));
    endtask : doEntry
    task automatic sysReset(input int j);
        word_t o, pc;
        int n;
        o = {$urandom, $urandom} & `MSW_IMPL_MASK;
        pc = {$urandom, $urandom};
        regWrite(`REG_MSW_OFF, o);
        nextPc <= pc;
        priorDone <= 1'b0;
        {lostAsyncInt, lostStoreError, lostFloatProgram} <= 3'b100 >> j;
        skew <= 4'($urandom);
        fire <= 1'b1;
        n = nRedir;
        if (j == 3) begin
            repeat (12) @(posedge core_clk);
            check(64'(nRedir - n), 64'h0);
            priorDone <= 1'b1;
        end
        waitRedirect(12);
        check(fetchAddr, (o[`MSW_VEC_HI] ? `VEC_HIGH_BASE : 64'h0) | 64'h100);
        @(posedge core_clk);
        {fire, lostAsyncInt, lostStoreError, lostFloatProgram} <= 4'h0;
        regRead(`REG_MSW_OFF, expWord(o, 1'b0));
        regRead(`REG_SRPC_OFF, pc);
        regRead(`REG_SRST_OFF, expSave(o, 10'h0, j == 3 && o[`MSW_RECOV]));
        regRead(`REG_RSTCAUSE_OFF, 64'h2);
        regWrite(`REG_RSTCAUSE_OFF, 64'h2);
        // let an edge pass so the next write strobe is not driven twice in one step
        @(posedge core_clk);
    endtask : sysReset
    task automatic reportAndStop;
        if (nMismatch == 0 && checksDone > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : reportAndStop
    // ============================================================
    // main sequence
    initial begin
        {rst_n, priorDone, excReq, excIsMachineCheck, asyncReq, fire, regWr, regRd} = '0;
        {lostAsyncInt, lostStoreError, lostFloatProgram, skew, regAddr, excInfo} = '0;
        {nextPc, regWrData, excOffset, asyncOffset} = '0;
        void'($urandom(80315));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        regRead(`REG_RSTCAUSE_OFF, 64'h1);
        regWrite(`REG_RSTCAUSE_OFF, 64'h1);
        regRead(`REG_RSTCAUSE_OFF, 64'h0);
        regRead(5'h04, 64'h0);
        regWrite(`REG_MSW_OFF, '1);
        regRead(`REG_MSW_OFF, `MSW_IMPL_MASK);
        for (k = 0; k < 12; k++) doEntry(k < 2 ? k[0] : 1'($urandom));
        regWrite(`REG_MSW_OFF, 64'h0);
        asyncOffset <= 20'h00900;
        asyncReq <= 1'b1;
        k = nRedir;
        repeat (8) @(posedge core_clk);
        check(64'(nRedir - k), 64'h0);
        regWrite(`REG_MSW_OFF, 64'h1 << `MSW_AIE);
        waitRedirect(4);
        check(64'(asyncAck), 64'h1);
        check(fetchAddr, 64'h900);
        @(posedge core_clk);
        asyncReq <= 1'b0;
        for (k = 0; k < 4; k++) sysReset(k);
        reportAndStop;
    end
    // hang guard, over twenty times the expected run
    initial begin
        repeat (5000) @(posedge core_clk);
        nMismatch++;
        reportAndStop;
    end
endmodule : test_exception_entry_state
